// ### logic/branch_cond_decode.sv
// Opcode decoder and flag test for the five conditional branches
`timescale 1ns/1ps
module branch_cond_decode
	import branch_pkg::*;
(
	// Instruction and flags
	input  wire logic [7:0] op_high,
	input  wire logic [4:0] flags,
	// Result
	output logic            is_branch,
	output logic            cond_true
);

	wire logic hit_neg_set   = (op_high == OP_NEG_SET);   // RULE1
	wire logic hit_carry_clr = (op_high == OP_CARRY_CLR); // RULE2
	wire logic hit_neg_clr   = (op_high == OP_NEG_CLR);   // RULE3
	wire logic hit_ovf_clr   = (op_high == OP_OVF_CLR);   // RULE4
	wire logic hit_zero_clr  = (op_high == OP_ZERO_CLR);  // RULE5

	assign is_branch = hit_neg_set | hit_carry_clr | hit_neg_clr | hit_ovf_clr | hit_zero_clr;
	assign cond_true = (hit_neg_set & flags[FLAG_NEG])     // RULE1
		| (hit_carry_clr & ~flags[FLAG_CARRY])             // RULE2
		| (hit_neg_clr & ~flags[FLAG_NEG])                 // RULE3
		| (hit_ovf_clr & ~flags[FLAG_OVF])                 // RULE4
		| (hit_zero_clr & ~flags[FLAG_ZERO]);              // RULE5

endmodule

// ### logic/branch_pkg.sv
// Package with opcodes, phase codes and carrier types for the conditional branch block
package branch_pkg;

	localparam int PC_W   = 21;
	localparam int WORD_W = 16;

	// High byte of each branch opcode
	localparam logic [7:0] OP_NEG_SET    = 8'hE6;
	localparam logic [7:0] OP_CARRY_CLR  = 8'hE3;
	localparam logic [7:0] OP_NEG_CLR    = 8'hE7;
	localparam logic [7:0] OP_OVF_CLR    = 8'hE5;
	localparam logic [7:0] OP_ZERO_CLR   = 8'hE1;

	// Fetch increment of the program counter, in bytes
	localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

	// Bit positions in the status flag carrier
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO  = 2;
	localparam int FLAG_OVF   = 3;
	localparam int FLAG_NEG   = 4;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_type;

	typedef enum logic [0:0] {
		CYC_EXEC  = 1'b0,
		CYC_EXTRA = 1'b1
	} cycle_type;

	// Instruction handed over by fetch
	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] word;
		logic [PC_W-1:0]   pc_inc;
	} fetch_type;

	// Update offered to the program counter
	typedef struct packed {
		logic            write;
		logic [PC_W-1:0] target;
	} pc_update_type;

endpackage

// ### logic/conditional_branch_exec.sv
// Execute stage for the five conditional relative branches
//
// Function
// RULE1 - Opcode high byte E6 is branch_if_negative and branches only when the negative flag is one.
// RULE2 - Opcode high byte E3 is branch_if_carry_clear and branches only when the carry flag is zero.
// RULE3 - Opcode high byte E7 is branch_if_negative_clear and branches only when the negative flag is zero.
// RULE4 - Opcode high byte E5 is branch_if_overflow_clear and branches only when the overflow flag is zero.
// RULE5 - Opcode high byte E1 is branch_if_zero_clear and branches only when the zero flag is zero.
// RULE6 - A taken branch adds twice the sign-extended 8-bit offset to the incremented program counter.
// RULE7 - The base is the instruction address plus two, where a not-taken branch simply continues.
// RULE8 - Each branch is one word, takes one cycle untaken and two taken, and changes no flag.
// RULE9 - A taken branch spends one extra full instruction cycle.
// RULE10 - Decode in Q1, read the literal in Q2, test in Q3, write the PC in Q4 if taken; the extra cycle is idle.
`timescale 1ns/1ps
module conditional_branch_exec
	import branch_pkg::*;
(
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	// Phase timing and instruction from fetch
	input  wire logic          q1_start,
	input  wire fetch_type     fetch,
	input  wire logic [4:0]    flags,
	// Program counter update and status
	output pc_update_type      pc_update,
	output logic               busy,
	output logic               flush,
	output logic               done
);

	// Sequencing state
	phase_type            phase_r;
	phase_type            phase_nxt;
	cycle_type            cycle_r;
	cycle_type            cycle_nxt;
	logic                 active_r;
	// Instruction captured in Q1 and the fields read from it
	logic [WORD_W-1:0]    word_r;
	logic [7:0]           lit_r;
	logic [PC_W-1:0]      base_r;
	logic                 taken_r;
	logic                 taken_nxt;
	// Output registers
	pc_update_type        pc_update_r;
	logic                 busy_r;
	logic                 flush_r;
	logic                 done_r;
	// Decoder results
	logic                 is_branch;
	logic                 cond_true;

	wire logic [7:0]      op_code = word_r[15:8];

	branch_cond_decode u_decode (
		.op_high   (op_code),
		.flags     (flags),
		.is_branch (is_branch),
		.cond_true (cond_true)
	);

	// Strobes of the running instruction; the idle cycle of a taken branch only counts phases
	wire logic            start      = q1_start & fetch.valid & ~active_r;
	wire logic            exec_cycle = (cycle_r == CYC_EXEC);
	wire logic            at_q2      = active_r & exec_cycle & (phase_r == PH_Q2);
	wire logic            at_q3      = active_r & exec_cycle & (phase_r == PH_Q3);
	wire logic            at_q4      = active_r & (phase_r == PH_Q4);
	wire logic            branch_hit = is_branch & cond_true;
	wire logic            jump_now   = at_q4 & exec_cycle & taken_r;
	wire logic            finish     = at_q4 & ~jump_now;

	// Offset doubled and sign-extended to PC width
	wire logic [PC_W-1:0] offset_ext;
	assign offset_ext[8:0] = {lit_r, 1'b0}; // RULE6
	for (genvar b = 9; b < PC_W; b = b + 1) begin : g_sign
		assign offset_ext[b] = lit_r[7]; // RULE6
	end
	wire logic [PC_W-1:0] target     = base_r + offset_ext; // RULE6 RULE7

	always_comb begin
		case (phase_r)
			PH_Q1:   phase_nxt = PH_Q2;
			PH_Q2:   phase_nxt = PH_Q3;
			PH_Q3:   phase_nxt = PH_Q4;
			PH_Q4:   phase_nxt = PH_Q1;
			default: phase_nxt = PH_Q1;
		endcase
	end

	// A taken branch appends one idle instruction cycle
	always_comb begin
		cycle_nxt = cycle_r;
		if (start) begin
			cycle_nxt = CYC_EXEC;
		end else if (jump_now) begin
			cycle_nxt = CYC_EXTRA; // RULE9
		end else if (finish) begin
			cycle_nxt = CYC_EXEC;
		end
	end

	always_comb begin
		taken_nxt = taken_r;
		if (at_q3) begin
			taken_nxt = branch_hit; // RULE10
		end else if (finish) begin
			taken_nxt = 1'b0;
		end
	end

	// Phase counter runs only while an instruction is in flight
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			phase_r <= PH_Q1;
		end else if (start) begin
			phase_r <= PH_Q2;
		end else if (active_r) begin
			phase_r <= phase_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cycle_r <= CYC_EXEC;
		end else begin
			cycle_r <= cycle_nxt;
		end
	end

	// New Q1 pulses are ignored until the instruction ends
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			active_r <= 1'b0;
		end else if (start) begin
			active_r <= 1'b1;
		end else if (finish) begin
			active_r <= 1'b0; // RULE8
		end
	end

	// Q1: the whole instruction is one word, captured as it arrives
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			word_r <= 16'h0000;
		end else if (start) begin
			word_r <= fetch.word; // RULE10 RULE8
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			base_r <= PC_RESET;
		end else if (start) begin
			base_r <= fetch.pc_inc; // RULE7
		end
	end

	// Q2: read the literal
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			lit_r <= 8'h00;
		end else if (at_q2) begin
			lit_r <= word_r[7:0]; // RULE10
		end
	end

	// Q3: flags are tested here and must be settled at this edge
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			taken_r <= 1'b0;
		end else begin
			taken_r <= taken_nxt;
		end
	end

	// Q4: load the PC only on a taken branch; the target holds until the next one
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pc_update_r <= '0;
		end else begin
			pc_update_r.write <= jump_now; // RULE10 RULE6
			if (jump_now) begin
				pc_update_r.target <= target; // RULE6
			end
		end
	end

	// Prefetched word is stale after a jump
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			flush_r <= 1'b0;
		end else begin
			flush_r <= jump_now;
		end
	end

	// Busy covers Q2 of the first cycle to the end of the last one, which is the idle one if taken
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
		end else if (start) begin
			busy_r <= 1'b1;
		end else if (finish) begin
			busy_r <= 1'b0;
		end
	end

	// Untaken ends in its own Q4, taken after the idle cycle; pc_inc already points past the branch
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= finish; // RULE7 RULE8
		end
	end

	// Flags are only read, never written
	assign pc_update = pc_update_r; // RULE8
	assign busy      = busy_r;
	assign flush     = flush_r;
	assign done      = done_r;

endmodule

// ### test/conditional_branch_exec_sva.sv
// Port checker for the conditional branch block
`timescale 1ns/1ps
module exec_checker
	import branch_pkg::*;
(
	// Clock and inputs
	input wire logic          sys_clk,
	input wire logic          reset_n,
	input wire logic          q1_start,
	input wire fetch_type     fetch,
	input wire logic [4:0]    flags,
	// Outputs
	input wire pc_update_type pc_update,
	input wire logic          busy,
	input wire logic          flush,
	input wire logic          done
);
	logic [7:0] op_r;
	wire        st = q1_start && fetch.valid && !busy;
	wire [7:0]  n = fetch.word[7:0];
	wire        tk = op_r == 8'hE6 & flags[4] | op_r == 8'hE3 & !flags[0] | op_r == 8'hE7 & !flags[4]
		| op_r == 8'hE5 & !flags[3] | op_r == 8'hE1 & !flags[2];
	always_ff @(posedge sys_clk)
		if (st) op_r <= fetch.word[15:8];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_tk; st ##2 tk |-> ##2 pc_update.write && flush; endproperty
	property p_nt; st ##2 !tk |-> !pc_update.write [*3] ##0 done; endproperty
	property p_tg; pc_update.write |-> pc_update.target == $past(fetch.pc_inc + {{12{n[7]}}, n, 1'b0}, 4); endproperty
	property p_x; pc_update.write |-> (busy && !done) [*4] ##1 done && !busy; endproperty
	property p_bz; st |=> busy [*3]; endproperty
	property p_fl; flush |-> pc_update.write; endproperty
	property p_hd; !pc_update.write |-> $stable(pc_update.target); endproperty
	property p_dn; done |=> !done; endproperty
	a_tk: assert property (p_tk) else $error("no write");
	a_nt: assert property (p_nt) else $error("bad untaken");
	a_tg: assert property (p_tg) else $error("bad target");
	a_x: assert property (p_x) else $error("bad extra cycle");
	a_bz: assert property (p_bz) else $error("not busy");
	a_fl: assert property (p_fl) else $error("stray flush");
	a_hd: assert property (p_hd) else $error("target moved");
	a_dn: assert property (p_dn) else $error("long done");
	c_tk: cover property (st ##2 tk);
	c_nt: cover property (st ##2 !tk);
	c_bb: cover property (done ##1 st);
endmodule

// ### test/testbench.sv
// Random branch bench with a result queue
`timescale 1ns/1ps
module testbench import branch_pkg::*;;
	logic          sys_clk = 0, reset_n = 0, q1_start = 0, tk, busy, flush, done;
	fetch_type     fetch = '0;
	logic [4:0]    flags = '0;
	pc_update_type pc_update;
	logic [7:0]    op, n;
	logic [22:0]   exp_q[$];
	int            err_count = 0, n_compared = 0;
	logic [7:0]    ops[6] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1, 8'hE2};
	always #2 sys_clk = ~sys_clk;
	conditional_branch_exec dut (.sys_clk(sys_clk), .reset_n(reset_n), .q1_start(q1_start), .fetch(fetch),
		.flags(flags), .pc_update(pc_update), .busy(busy), .flush(flush), .done(done));
	task automatic chk(string nm, logic [22:0] s, logic [22:0] x);
		n_compared++;
		if (s !== x) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, x, s);
		end
	endtask
	task end_sim;
		if (err_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if ((pc_update.write | done) !== 1'b0)
			chk("result", {flush, pc_update.write, pc_update.write ? pc_update.target : 21'h0}, exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'h0A88827B));
		repeat (4) @(posedge sys_clk);
		reset_n <= 1;
		for (int i = 0; i < 300; i++) begin
			op = i < 2 ? OP_NEG_SET : ops[$urandom_range(5)];
			n = i < 2 ? {i[0], {7{~i[0]}}} : 8'($urandom);
			q1_start <= 1;
			fetch <= '{1'b1, {op, n}, 21'($urandom)};
			flags <= i < 2 ? 5'h10 : 5'($urandom);
			@(posedge sys_clk);
			tk = op == 8'hE6 & flags[4] | op == 8'hE3 & !flags[0] | op == 8'hE7 & !flags[4]
				| op == 8'hE5 & !flags[3] | op == 8'hE1 & !flags[2];
			if (tk) exp_q.push_back({2'b11, fetch.pc_inc + {{12{n[7]}}, n, 1'b0}});
			exp_q.push_back('0);
			@(posedge sys_clk);
			q1_start <= 0;
			// Next Q1 lands on the done cycle, or one cycle later
			repeat ((tk ? 6 : 2) + $urandom_range(1)) @(posedge sys_clk);
		end
		repeat (10) @(posedge sys_clk);
		// Taken branch cut by a reset in its Q4, then a Q1 without a valid word
		q1_start <= 1;
		fetch <= '{1'b1, {OP_NEG_SET, 8'h05}, 21'($urandom)};
		flags <= 5'h10;
		repeat (3) @(posedge sys_clk);
		reset_n <= 0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1;
		fetch.valid <= 0;
		@(negedge sys_clk);
		chk("reset", {busy, pc_update}, '0);
		@(posedge sys_clk);
		q1_start <= 0;
		@(negedge sys_clk);
		chk("no valid", {busy, pc_update}, '0);
		chk("pending", 23'(exp_q.size()), '0);
		end_sim;
	end
	initial begin
		#20000;
		err_count++;
		end_sim;
	end
endmodule
bind conditional_branch_exec exec_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .q1_start(q1_start),
	.fetch(fetch), .flags(flags), .pc_update(pc_update), .busy(busy), .flush(flush), .done(done));
